/* File: rtl/dpbs_core.sv */
`timescale 1ns/1ps
module dpbs_core
  import dpbs_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              srst_i,
  // Register port
  input  wire logic [RA_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [DATA_W-1:0]      rdata_o,
  // Interrupt hold during swap
  output logic                   irq_hold_o,
  // Device link
  dpbs_if.core                   link
);

  typedef enum logic {
    DPBS_C_IDLE,
    DPBS_C_JUMP
  } dpbs_cst_e;

  typedef struct packed {
    dpbs_cst_e         st;
    logic [DATA_W-1:0] rdata;
    logic              hold;
    logic              err;
    logic              key_wr;
    logic [KEY_W-1:0]  key_data;
    logic              swap_ex;
    logic              jump_ex;
    logic [ADDR_W-1:0] jump_addr;
    logic              op_req;
    logic [OP_W-1:0]   op_sel;
    logic [ADDR_W-1:0] op_addr;
    logic              lim_wr;
    logic              lim_part;
    logic [LIM_W-1:0]  lim_data;
    logic              done_clr;
    logic [ADDR_W-1:0] pc;
  } dpbs_core_s;

  dpbs_core_s c_r;
  dpbs_core_s c_nxt;

  always_comb begin
    c_nxt = c_r;
    c_nxt.rdata = '0;
    c_nxt.key_wr = 1'b0;
    c_nxt.swap_ex = 1'b0;
    c_nxt.jump_ex = 1'b0;
    c_nxt.op_req = 1'b0;
    c_nxt.lim_wr = 1'b0;
    c_nxt.done_clr = 1'b0;
    if (c_r.st == DPBS_C_JUMP) begin
      // R9 jump issued right after the swap
      c_nxt.jump_ex = 1'b1;
      c_nxt.st = DPBS_C_IDLE;
      // R10 interrupts released once the jump is out
      c_nxt.hold = 1'b0;
    end else if (wr_i) begin
      if (addr_i == REG_KEY) begin
        c_nxt.key_wr = 1'b1;
        c_nxt.key_data = wdata_i[KEY_W-1:0];
        // R10 interrupts held from the first key write
        // Second key keeps the hold so it spans the swap
        c_nxt.hold = wdata_i[KEY_W-1:0] == KEY_FIRST ||
                     (c_r.hold && wdata_i[KEY_W-1:0] == KEY_SECOND);
      end else if (addr_i == REG_SWAP) begin
        // R12 target should be a reinitialising routine
        c_nxt.swap_ex = 1'b1;
        c_nxt.jump_addr = wdata_i[ADDR_W-1:0];
        c_nxt.st = DPBS_C_JUMP;
      end else if (addr_i == REG_OP) begin
        c_nxt.op_req = 1'b1;
        c_nxt.op_sel = wdata_i[OPW_SEL_LSB +: OP_W];
        c_nxt.op_addr = wdata_i[ADDR_W-1:0];
      end else if (addr_i == REG_LIM) begin
        c_nxt.lim_wr = 1'b1;
        c_nxt.lim_part = wdata_i[LIMW_PART];
        c_nxt.lim_data = wdata_i[LIM_W-1:0];
      end else if (addr_i == REG_STAT) begin
        // R17 software clears the done flag
        c_nxt.done_clr = wdata_i[ST_DONE];
        if (wdata_i[ST_ERR]) begin
          c_nxt.err = 1'b0;
        end
      end
    end
    if (link.op_err) begin
      c_nxt.err = 1'b1;
    end
    if (link.pc_load) begin
      c_nxt.pc = link.pc_addr;
    end
    if (rd_i) begin
      if (addr_i == REG_STAT) begin
        // R16 status seen by software
        c_nxt.rdata[ST_DONE] = link.swap_done;
        c_nxt.rdata[ST_P2] = link.p2_active;
        c_nxt.rdata[ST_BUSY] = link.op_busy;
        c_nxt.rdata[ST_ERR] = c_r.err;
      end else if (addr_i == REG_PC) begin
        c_nxt.rdata[ADDR_W-1:0] = c_r.pc;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      c_r <= '{st: DPBS_C_IDLE, default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  assign rdata_o        = c_r.rdata;
  assign irq_hold_o     = c_r.hold;
  assign link.key_wr    = c_r.key_wr;
  assign link.key_data  = c_r.key_data;
  assign link.swap_ex   = c_r.swap_ex;
  assign link.jump_ex   = c_r.jump_ex;
  assign link.jump_addr = c_r.jump_addr;
  assign link.op_req    = c_r.op_req;
  assign link.op_sel    = c_r.op_sel;
  assign link.op_addr   = c_r.op_addr;
  assign link.lim_wr    = c_r.lim_wr;
  assign link.lim_part  = c_r.lim_part;
  assign link.lim_data  = c_r.lim_data;
  assign link.done_clr  = c_r.done_clr;

endmodule : dpbs_core

/* File: rtl/dpbs_dev.sv */
`timescale 1ns/1ps
module dpbs_dev
  import dpbs_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              srst_i,
  // Configuration words and modes
  input  wire logic [SEQ_W-1:0]  seq_word_p1_i,
  input  wire logic [SEQ_W-1:0]  seq_word_p2_i,
  input  wire logic              prot_mode_i,
  input  wire logic              priv_mode_i,
  // Flash array command side
  output logic                   flash_cmd_o,
  output logic [OP_W-1:0]        flash_op_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  input  wire logic              flash_done_i,
  // Status
  output logic                   active_p2_o,
  output logic [LIM_W-1:0]       boot_limit_o,
  // Core link
  dpbs_if.dev                    link
);

  typedef enum logic [1:0] {
    DPBS_BOOT,
    DPBS_RUN,
    DPBS_BUSY
  } dpbs_st_e;

  typedef enum logic [1:0] {
    DPBS_LOCKED,
    DPBS_KEY1,
    DPBS_OPEN
  } dpbs_key_e;

  typedef struct packed {
    dpbs_st_e          st;
    dpbs_key_e         key;
    logic              prot;
    logic              priv;
    logic              act;
    logic              done;
    logic              pc_load;
    logic [ADDR_W-1:0] pc_addr;
    logic              err;
    logic              cmd;
    logic              busy;
    logic [OP_W-1:0]   op;
    logic [ADDR_W-1:0] addr;
    logic [LIM_W-1:0]  lim_p1;
    logic [LIM_W-1:0]  lim_p2;
    logic [LIM_W-1:0]  lim_out;
  } dpbs_dev_s;

  dpbs_dev_s s_r;
  dpbs_dev_s s_nxt;

  logic              v1;
  logic              v2;
  logic [SEQN_W-1:0] n1;
  logic [SEQN_W-1:0] n2;
  logic              phys;
  logic              any_req;
  logic              part_op;

  // Places an in-partition offset into the given partition
  function automatic logic [ADDR_W-1:0] dpbs_place(
    input logic              part,
    input logic [ADDR_W-1:0] a
  );
    return {part, a[INACT_BIT-1:0]};
  endfunction : dpbs_place

  assign v1 = dpbs_seq_valid(seq_word_p1_i);
  assign v2 = dpbs_seq_valid(seq_word_p2_i);
  assign n1 = seq_word_p1_i[SEQN_W-1:0];
  assign n2 = seq_word_p2_i[SEQN_W-1:0];
  // R3 offset bit selects the inactive partition
  assign phys = s_r.act ^ link.op_addr[INACT_BIT];
  assign any_req = link.swap_ex | link.jump_ex | link.op_req | link.lim_wr;
  assign part_op = link.op_sel == OP_PART;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pc_load = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.cmd = 1'b0;
    case (s_r.st)
      DPBS_BOOT: begin
        // Link requests in the boot cycle are dropped, except done_clr, which still clears the done flag
        // R13 configuration taken only here, never on swap
        s_nxt.prot = prot_mode_i;
        s_nxt.priv = priv_mode_i;
        // R5 lower valid number wins
        // R6 single valid wins, none valid gives partition 1
        if (v1 && v2) begin
          s_nxt.act = n2 < n1;
        end else begin
          s_nxt.act = v2 && !v1;
        end
        s_nxt.st = DPBS_RUN;
      end
      DPBS_RUN, DPBS_BUSY: begin
        // R14 key sequence must directly precede the swap
        // Any other link action except done_clr breaks the unlock
        if (link.key_wr) begin
          if (link.key_data == KEY_SECOND && s_r.key == DPBS_KEY1) begin
            s_nxt.key = DPBS_OPEN;
          end else if (link.key_data == KEY_FIRST) begin
            s_nxt.key = DPBS_KEY1;
          end else begin
            s_nxt.key = DPBS_LOCKED;
          end
        end else if (any_req) begin
          s_nxt.key = DPBS_LOCKED;
        end
        if (link.swap_ex && s_r.key == DPBS_OPEN) begin
          // R8 partitions exchanged without reset
          // R11 only the partition select changes
          s_nxt.act = ~s_r.act;
        end
        // R8 jump lands in the now active partition
        // R15 locked swap left act as it was
        if (link.jump_ex) begin
          s_nxt.pc_load = 1'b1;
          s_nxt.pc_addr = dpbs_place(s_r.act, link.jump_addr);
        end
        // R19 per-partition segment limit
        // R21 privileged mode refuses limit changes
        if (link.lim_wr) begin
          if (s_r.priv) begin
            s_nxt.err = 1'b1;
          end else if (link.lim_part) begin
            s_nxt.lim_p2 = link.lim_data;
          end else begin
            s_nxt.lim_p1 = link.lim_data;
          end
        end
        // One command in flight; requests meanwhile refused
        if (s_r.st == DPBS_BUSY) begin
          if (flash_done_i) begin
            s_nxt.st = DPBS_RUN;
          end
          if (link.op_req) begin
            s_nxt.err = 1'b1;
          end
        end else if (link.op_req) begin
          // R1 active partition never erased, fetch not stalled
          if (!link.op_addr[INACT_BIT] && !part_op) begin
            s_nxt.err = 1'b1;
          // R20 protected mode blocks partition 1
          end else if (s_r.prot &&
                       (part_op ? ~s_r.act : phys) == 1'b0) begin
            s_nxt.err = 1'b1;
          end else if (part_op) begin
            // R2 whole inactive partition erase
            s_nxt.cmd = 1'b1;
            s_nxt.op = link.op_sel;
            s_nxt.addr = dpbs_place(~s_r.act, '0);
            s_nxt.st = DPBS_BUSY;
          end else if (link.op_sel == OP_PAGE || link.op_sel == OP_WORD) begin
            s_nxt.cmd = 1'b1;
            s_nxt.op = link.op_sel;
            s_nxt.addr = dpbs_place(phys, link.op_addr);
            s_nxt.st = DPBS_BUSY;
          end else begin
            s_nxt.err = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = DPBS_BOOT;
      end
    endcase
    // R16 status flag on a real swap
    // R18 sticky, set wins over clear
    if (link.done_clr) begin
      s_nxt.done = 1'b0;
    end
    if (s_r.st != DPBS_BOOT && link.swap_ex && s_r.key == DPBS_OPEN) begin
      s_nxt.done = 1'b1;
    end
    s_nxt.lim_out = s_nxt.act ? s_nxt.lim_p2 : s_nxt.lim_p1;
    // Busy kept in a flop so the status pin is registered
    s_nxt.busy = s_nxt.st == DPBS_BUSY;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_r <= '{st: DPBS_BOOT, key: DPBS_LOCKED, lim_p1: LIM_RST,
               lim_p2: LIM_RST, lim_out: LIM_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flash_cmd_o    = s_r.cmd;
  assign flash_op_o     = s_r.op;
  assign flash_addr_o   = s_r.addr;
  assign active_p2_o    = s_r.act;
  assign boot_limit_o   = s_r.lim_out;
  assign link.pc_load   = s_r.pc_load;
  assign link.pc_addr   = s_r.pc_addr;
  assign link.op_busy   = s_r.busy;
  assign link.op_err    = s_r.err;
  assign link.swap_done = s_r.done;
  assign link.p2_active = s_r.act;

endmodule : dpbs_dev

/* File: rtl/dpbs_if.sv */
`timescale 1ns/1ps
interface dpbs_if;
  import dpbs_pkg::*;
  logic              key_wr;
  logic [KEY_W-1:0]  key_data;
  logic              swap_ex;
  logic              jump_ex;
  logic [ADDR_W-1:0] jump_addr;
  logic              op_req;
  logic [OP_W-1:0]   op_sel;
  logic [ADDR_W-1:0] op_addr;
  logic              lim_wr;
  logic              lim_part;
  logic [LIM_W-1:0]  lim_data;
  logic              done_clr;
  logic              pc_load;
  logic [ADDR_W-1:0] pc_addr;
  logic              op_busy;
  logic              op_err;
  logic              swap_done;
  logic              p2_active;
  modport dev (input key_wr, key_data, swap_ex, jump_ex, jump_addr, op_req,
               op_sel, op_addr, lim_wr, lim_part, lim_data, done_clr,
               output pc_load, pc_addr, op_busy, op_err, swap_done,
               p2_active);
  modport core (output key_wr, key_data, swap_ex, jump_ex, jump_addr,
                op_req, op_sel, op_addr, lim_wr, lim_part, lim_data,
                done_clr,
                input pc_load, pc_addr, op_busy, op_err, swap_done,
                p2_active);
endinterface : dpbs_if

/* File: rtl/dpbs_pkg.sv */
// Overview of operation
// R1 - Inactive partition writable while active keeps running
// R2 - Operation code erases whole inactive partition
// R3 - Software adds 0x400000 for inactive writes
// R4 - Sequence word: number low, complement high
// R5 - Reset picks partition with lower valid number
// R6 - One valid wins; none valid gives partition 1
// R7 - Valid only when high half complements low
// R8 - Unlocked swap exchanges partitions, jump lands there
// R9 - Jump always follows the swap instruction
// R10 - Interrupts held off during swap sequence
// R11 - Swap leaves peripherals, interrupts, RAM untouched
// R12 - After swap, jump to reinitialising routine
// R13 - Configuration words not reapplied on swap
// R14 - Swap needs key 0x55 then 0xAA first
// R15 - Locked swap is a no-op; jump stays
// R16 - Swap-done flag and active-partition status bit
// R17 - Software polls then clears swap-done flag
// R18 - Swap-done sticky until cleared, set again
// R19 - Each partition has its own segment setting
// R20 - Protected mode blocks erase/write of partition 1
// R21 - Privileged mode blocks boot limit changes
package dpbs_pkg;
  localparam int ADDR_W  = 23;
  localparam int SEQ_W   = 24;
  localparam int SEQN_W  = 12;
  localparam int KEY_W   = 8;
  localparam int OP_W    = 4;
  localparam int LIM_W   = 16;
  localparam int DATA_W  = 32;
  localparam int RA_W    = 4;
  localparam int INACT_BIT = 22;
  localparam logic [ADDR_W-1:0] INACT_OFS = 23'h400000;
  localparam logic [KEY_W-1:0]  KEY_FIRST  = 8'h55;
  localparam logic [KEY_W-1:0]  KEY_SECOND = 8'haa;
  // Flash operation select codes
  localparam logic [OP_W-1:0] OP_WORD = 4'h1;
  localparam logic [OP_W-1:0] OP_PAGE = 4'h3;
  localparam logic [OP_W-1:0] OP_PART = 4'h4;
  localparam logic [LIM_W-1:0] LIM_RST = 16'h0000;
  // Controller register map
  localparam logic [RA_W-1:0] REG_KEY  = 4'h0;
  localparam logic [RA_W-1:0] REG_SWAP = 4'h1;
  localparam logic [RA_W-1:0] REG_OP   = 4'h2;
  localparam logic [RA_W-1:0] REG_LIM  = 4'h3;
  localparam logic [RA_W-1:0] REG_STAT = 4'h4;
  localparam logic [RA_W-1:0] REG_PC   = 4'h5;
  localparam int OPW_SEL_LSB = 24;
  localparam int LIMW_PART   = 16;
  localparam int ST_DONE     = 0;
  localparam int ST_P2       = 1;
  localparam int ST_BUSY     = 2;
  localparam int ST_ERR      = 3;

  // R7 validity check
  function automatic logic dpbs_seq_valid(input logic [SEQ_W-1:0] w);
    // R4 field split
    return w[SEQ_W-1:SEQN_W] == ~w[SEQN_W-1:0];
  endfunction : dpbs_seq_valid
endpackage : dpbs_pkg

/* File: sim/dpbs_asserts.sv */
`timescale 1ns/1ps
module dpbs_asserts
  import dpbs_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk_i,
  input wire logic              srst_i,
  // Core to device
  input wire logic              key_wr,
  input wire logic [KEY_W-1:0]  key_data,
  input wire logic              swap_ex,
  input wire logic              jump_ex,
  input wire logic [ADDR_W-1:0] jump_addr,
  input wire logic              op_req,
  input wire logic [OP_W-1:0]   op_sel,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic              done_clr,
  // Device to core
  input wire logic              pc_load,
  input wire logic [ADDR_W-1:0] pc_addr,
  input wire logic              op_err,
  input wire logic              swap_done,
  input wire logic              p2_active
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  property p_swap;
    key_wr && key_data == KEY_FIRST ##1 key_wr && key_data == KEY_SECOND
      ##1 swap_ex |=> p2_active != $past(p2_active) && swap_done;
  endproperty
  a_swap: assert property (p_swap)
    else $error("unlocked swap did not toggle partition");
  property p_nop;
    swap_ex && !($past(key_wr) && $past(key_data) == KEY_SECOND)
      |=> $stable(p2_active);
  endproperty
  a_nop: assert property (p_nop)
    else $error("locked swap changed partition");
  property p_jump;
    jump_ex |=> pc_load && pc_addr == {p2_active, $past(jump_addr[21:0])};
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");
  property p_cause;
    !jump_ex |=> !pc_load;
  endproperty
  a_cause: assert property (p_cause)
    else $error("pc load without jump");
  property p_hold;
    swap_done && !done_clr |=> swap_done;
  endproperty
  a_hold: assert property (p_hold)
    else $error("swap done flag dropped");
  property p_clr;
    done_clr && !swap_ex |=> !swap_done;
  endproperty
  a_clr: assert property (p_clr)
    else $error("swap done flag not cleared");
  // Only a swap may move the active partition after boot
  property p_act;
    !swap_ex && !$past(srst_i) |=> $stable(p2_active);
  endproperty
  a_act: assert property (p_act)
    else $error("active partition changed without swap");
  property p_refuse;
    op_req && !op_addr[INACT_BIT] && op_sel != OP_PART |=> op_err;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("active partition op not refused");

  c_swap: cover property (key_wr ##1 key_wr ##1 swap_ex);
  c_err: cover property (op_err);
  c_pc: cover property (pc_load && swap_done);
endmodule : dpbs_asserts

/* File: sim/dpbs_bench.sv */
`timescale 1ns/1ps
module dpbs_bench;
  import dpbs_pkg::*;
  logic              ref_clk_i, srst_i, prot, priv, fdone, wr, rd;
  logic              irq, hs, fcmd, act;
  logic [SEQ_W-1:0]  seq1, seq2;
  logic [RA_W-1:0]   addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [OP_W-1:0]   fop_s;
  logic [ADDR_W-1:0] faddr;
  logic [LIM_W-1:0]  blim;
  int                num_errors, cmp_count;
  // Boot table: P1 word, P2 word, expected P2 active
  logic [SEQ_W-1:0]  t1 [5] = '{24'hffa005, 24'hffd002, 24'hffa006,
                                24'h000000, 24'hff6009};
  logic [SEQ_W-1:0]  t2 [5] = '{24'hffc003, 24'hff6009, 24'hff6009,
                                24'h123456, 24'hff6008};
  logic [4:0]        ea = 5'b00101;

  dpbs_if lnk ();
  dpbs_dev dpbs_dev_inst (.ref_clk_i, .srst_i, .seq_word_p1_i(seq1),
    .seq_word_p2_i(seq2), .prot_mode_i(prot), .priv_mode_i(priv),
    .flash_cmd_o(fcmd), .flash_op_o(fop_s), .flash_addr_o(faddr),
    .flash_done_i(fdone), .active_p2_o(act), .boot_limit_o(blim),
    .link(lnk));
  dpbs_core dpbs_core_inst (.ref_clk_i, .srst_i, .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .irq_hold_o(irq), .link(lnk));
  dpbs_asserts dpbs_asserts_inst (.ref_clk_i, .srst_i,
    .key_wr(lnk.key_wr), .key_data(lnk.key_data), .swap_ex(lnk.swap_ex),
    .jump_ex(lnk.jump_ex), .jump_addr(lnk.jump_addr),
    .op_req(lnk.op_req), .op_sel(lnk.op_sel), .op_addr(lnk.op_addr),
    .done_clr(lnk.done_clr), .pc_load(lnk.pc_load),
    .pc_addr(lnk.pc_addr), .op_err(lnk.op_err),
    .swap_done(lnk.swap_done), .p2_active(lnk.p2_active));

  task automatic chk(input string n, input logic [DATA_W-1:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrt(input logic [RA_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
  endtask : wrt
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [RA_W-1:0] a, input logic [DATA_W-1:0] e,
                     input string n);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    // Hold sampled mid-cycle, while the strobe stands
    @(negedge ref_clk_i);
    hs = irq;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask : rdc
  task automatic cyc(input int n);
    wr <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic boot(input logic [SEQ_W-1:0] a, b, input logic p, q);
    srst_i <= 1'b1;
    seq1 <= a;
    seq2 <= b;
    prot <= p;
    priv <= q;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    cyc(3);
  endtask : boot
  task automatic sw(input logic [22:0] t, input logic [DATA_W-1:0] pc, st);
    wrt(REG_KEY, 32'h55);
    wrt(REG_KEY, 32'haa);
    wrt(REG_SWAP, 32'(t));
    rdc(4'hf, 32'h0, "unmapped");
    chk("irq hold", 32'h1, 32'(hs));
    cyc(6);
    rdc(REG_PC, pc, "pc");
    chk("irq hold", 32'h0, 32'(hs));
    rdc(REG_STAT, st, "stat");
  endtask : sw
  task automatic fop(input logic [OP_W-1:0] s, input logic [ADDR_W-1:0] a, e);
    int i;
    wrt(REG_OP, 32'({s, 1'b0, a}));
    wr <= 1'b0;
    for (i = 0; i < 8 && fcmd !== 1'b1; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("cmd", 32'h1, 32'(fcmd));
    chk("op", 32'(s), 32'(fop_s));
    chk("addr", 32'(e), 32'(faddr));
    rdc(REG_STAT, 32'h4, "busy");
    fdone <= 1'b1;
    @(posedge ref_clk_i);
    fdone <= 1'b0;
    cyc(2);
    rdc(REG_STAT, 32'h0, "idle");
  endtask : fop
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    num_errors++;
    finish_test;
  end

  initial begin
    num_errors = 0;
    cmp_count = 0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    fdone = 1'b0;
    for (int i = 0; i < 5; i++) begin
      boot(t1[i], t2[i], 1'b0, 1'b0);
      chk("active", 32'(ea[i]), 32'(act));
    end
    $display("test boot done");
    boot(t1[1], t2[1], 1'b0, 1'b0);
    wrt(REG_KEY, 32'haa);
    wrt(REG_KEY, 32'h55);
    wrt(REG_SWAP, 32'h123);
    cyc(6);
    rdc(REG_PC, 32'h123, "pc");
    rdc(REG_STAT, 32'h0, "stat");
    wrt(4'h9, 32'hffffffff);
    rdc(4'h9, 32'h0, "unmapped");
    $display("test locked done");
    // New words must not be picked up by a soft swap
    seq1 <= t1[0];
    seq2 <= t2[0];
    sw(23'h40, 32'h400040, 32'h3);
    wrt(REG_STAT, 32'h1);
    cyc(2);
    rdc(REG_STAT, 32'h2, "stat");
    sw(23'h80, 32'h80, 32'h1);
    wrt(REG_STAT, 32'h1);
    cyc(2);
    $display("test swap done");
    fop(OP_PAGE, 23'h400010, 23'h400010);
    fop(OP_WORD, 23'h400020, 23'h400020);
    fop(OP_PART, 23'h0, 23'h400000);
    wrt(REG_OP, 32'({OP_PAGE, 1'b0, 23'h10}));
    cyc(2);
    rdc(REG_STAT, 32'h8, "stat");
    wrt(REG_STAT, 32'h8);
    wrt(REG_OP, 32'({4'h7, 1'b0, 23'h400000}));
    cyc(2);
    rdc(REG_STAT, 32'h8, "stat");
    wrt(REG_STAT, 32'h8);
    wrt(REG_LIM, 32'h123);
    wrt(REG_LIM, 32'h10456);
    cyc(2);
    chk("limit", 32'h123, 32'(blim));
    $display("test flash done");
    boot(t1[0], t2[0], 1'b1, 1'b1);
    wrt(REG_OP, 32'({OP_PAGE, 1'b0, 23'h400010}));
    cyc(2);
    rdc(REG_STAT, 32'ha, "stat");
    wrt(REG_STAT, 32'h8);
    wrt(REG_OP, 32'({OP_PART, 1'b0, 23'h0}));
    cyc(2);
    rdc(REG_STAT, 32'ha, "stat");
    wrt(REG_STAT, 32'h8);
    wrt(REG_LIM, 32'h777);
    cyc(2);
    rdc(REG_STAT, 32'ha, "stat");
    chk("limit", 32'h0, 32'(blim));
    $display("test modes done");
    finish_test;
  end
endmodule : dpbs_bench
